// File: rtl/nsx_pkg.sv
// shared constants and types for the nibble-exchange / table-read executor
package nsx_pkg;

    // widths
    localparam int DATA_W     = 8;
    localparam int PTR_W      = 21;
    localparam int BANK_SEL_W = 6;
    localparam int PWORD_W    = 16;

    // opcode patterns: opcode[15:10] for file ops, opcode[15:2] for the table read
    localparam logic [5:0]  OPC_SWAP    = 6'h0e;
    localparam logic [5:0]  OPC_SUBB    = 6'h16;
    localparam logic [13:0] OPC_PMEM_RD = 14'h0002;

    // opcode field positions
    localparam int OPF_DEST = 9;
    localparam int OPF_BANK = 8;

    // file addressing limits
    localparam logic [7:0] ILO_LIMIT    = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;

    // table-read pointer modes (opcode[1:0])
    localparam logic [1:0] TBL_NOCHG   = 2'h0;
    localparam logic [1:0] TBL_POSTINC = 2'h1;
    localparam logic [1:0] TBL_POSTDEC = 2'h2;
    localparam logic [1:0] TBL_PREINC  = 2'h3;

    // clock steps inside an instruction (four clocks per instruction cycle)
    localparam logic [2:0] CYC_ZERO      = 3'h0;
    localparam logic [2:0] CYC_STEP      = 3'h1;
    localparam logic [2:0] CYC_FILE_RD   = 3'h1;
    localparam logic [2:0] CYC_FILE_PROC = 3'h2;
    localparam logic [2:0] CYC_FILE_LAST = 3'h3;
    localparam logic [2:0] CYC_PMEM_REQ  = 3'h4;
    localparam logic [2:0] CYC_PMEM_CAP  = 3'h6;
    localparam logic [2:0] CYC_TBL_LAST  = 3'h7;

    // status flag bit positions
    localparam int FLAGS_W = 5;
    localparam int FLG_C   = 0;
    localparam int FLG_DC  = 1;
    localparam int FLG_Z   = 2;
    localparam int FLG_OV  = 3;
    localparam int FLG_N   = 4;

    typedef enum logic [1:0] {
        NSX_IDLE,
        NSX_FILE,
        NSX_TABLE
    } nsx_state_type;

endpackage

// File: rtl/nsx_addr_calc.sv
// file operand address resolver: access bank, banked, indexed literal offset
`timescale 1ns/100ps
`default_nettype none

module nsx_addr_calc #(
    parameter int BANK_SEL_W = nsx_pkg::BANK_SEL_W,
    parameter int ADDR_W     = BANK_SEL_W + 8
) (
    // operand fields
    input  wire logic [7:0]            f_i,
    input  wire logic                  bank_i,
    // addressing context
    input  wire logic [BANK_SEL_W-1:0] bank_select_register_i,
    input  wire logic                  ext_set_i,
    input  wire logic [ADDR_W-1:0]     ilo_base_i,
    // resolved address
    output logic      [ADDR_W-1:0]     addr_o
);

    // indexed literal offset wins over the access bank only for low operands;
    // the offset sum wraps inside the address width rather than saturating
    always_comb begin
        if (bank_i) begin
            addr_o = {bank_select_register_i, f_i};
        end else if (ext_set_i && (f_i <= nsx_pkg::ILO_LIMIT)) begin
            addr_o = ilo_base_i + {{BANK_SEL_W{1'b0}}, f_i};
        end else if (f_i < nsx_pkg::ACCESS_SPLIT) begin
            addr_o = {{BANK_SEL_W{1'b0}}, f_i};
        end else begin
            addr_o = {{BANK_SEL_W{1'b1}}, f_i};
        end
    end

endmodule
`default_nettype wire

// File: rtl/nsx_exec.sv
// executor for nibble exchange, subtract with borrow and program memory read
`timescale 1ns/100ps
`default_nettype none

module nsx_exec #(
    parameter int PTR_W      = nsx_pkg::PTR_W,
    parameter int BANK_SEL_W = nsx_pkg::BANK_SEL_W,
    parameter int ADDR_W     = BANK_SEL_W + 8
) (
    // clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       rstn_i,
    // instruction issue and core context
    input  wire logic                       issue_i,
    input  wire logic [15:0]                opcode_i,
    input  wire logic [7:0]                 w_i,
    input  wire logic                       carry_i,
    input  wire logic [BANK_SEL_W-1:0]      bank_select_register_i,
    input  wire logic                       ext_set_i,
    input  wire logic [ADDR_W-1:0]          ilo_base_i,
    // program pointer load
    input  wire logic                       ptr_load_i,
    input  wire logic [PTR_W-1:0]           ptr_data_i,
    // memory read data
    input  wire logic [7:0]                 file_rdata_i,
    input  wire logic [nsx_pkg::PWORD_W-1:0] pmem_rdata_i,
    // status
    output logic                            busy_o,
    // data register file
    output logic [ADDR_W-1:0]               file_addr_o,
    output logic                            file_rd_o,
    output logic                            file_wr_o,
    output logic [7:0]                      file_wdata_o,
    // accumulator and flags
    output logic                            w_wr_o,
    output logic [7:0]                      w_wdata_o,
    output logic                            status_wr_o,
    output logic [nsx_pkg::FLAGS_W-1:0]     flags_o,
    // program memory
    output logic [PTR_W-2:0]                pmem_addr_o,
    output logic                            pmem_rd_o,
    output logic [PTR_W-1:0]                program_pointer_o,
    output logic [7:0]                      fetched_byte_latch_o
);

    localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // nine-bit difference; bit 8 set means a borrow came out
    function automatic logic [8:0] sub_borrow(input logic [7:0] a, input logic [7:0] b, input logic bw);
        sub_borrow = {1'b0, a} - {1'b0, b} - {8'h00, bw};
    endfunction

    logic [7:0]        f_field;
    logic              is_swap;
    logic              is_subb;
    logic              is_tbl;
    logic              accept;
    logic [ADDR_W-1:0] eff_addr;

    nsx_pkg::nsx_state_type state_r;
    nsx_pkg::nsx_state_type state_nxt;

    // unknown opcodes are simply not taken
    assign f_field = opcode_i[7:0];
    assign is_swap = (opcode_i[15:10] == nsx_pkg::OPC_SWAP);
    assign is_subb = (opcode_i[15:10] == nsx_pkg::OPC_SUBB);
    assign is_tbl  = (opcode_i[15:2] == nsx_pkg::OPC_PMEM_RD);
    assign accept  = issue_i && (state_r == nsx_pkg::NSX_IDLE) && (is_swap || is_subb || is_tbl);

    nsx_addr_calc #(
        .BANK_SEL_W             (BANK_SEL_W),
        .ADDR_W                 (ADDR_W)
    ) u_addr (
        .f_i                    (f_field),
        .bank_i                 (opcode_i[nsx_pkg::OPF_BANK]),
        .bank_select_register_i (bank_select_register_i),
        .ext_set_i              (ext_set_i),
        .ilo_base_i             (ilo_base_i),
        .addr_o                 (eff_addr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer state

    logic [2:0]                    cyc_r, cyc_nxt;
    logic                          busy_r, busy_nxt;
    logic                          swap_r, swap_nxt;
    logic                          dest_r, dest_nxt;
    logic [1:0]                    mode_r, mode_nxt;
    logic [7:0]                    w_r, w_nxt;
    logic                          c_r, c_nxt;
    logic [7:0]                    opnd_r, opnd_nxt;
    logic [ADDR_W-1:0]             faddr_r, faddr_nxt;
    logic                          frd_r, frd_nxt;
    logic                          fwr_r, fwr_nxt;
    logic [7:0]                    fwdata_r, fwdata_nxt;
    logic                          wwr_r, wwr_nxt;
    logic [7:0]                    wwdata_r, wwdata_nxt;
    logic                          swr_r, swr_nxt;
    logic [nsx_pkg::FLAGS_W-1:0]   flags_r, flags_nxt;
    logic [PTR_W-2:0]              paddr_r, paddr_nxt;
    logic                          prd_r, prd_nxt;
    logic [PTR_W-1:0]              ptr_r, ptr_nxt;                  // byte address
    logic [7:0]                    latch_r, latch_nxt;
    logic [8:0]                    diff;
    logic [8:0]                    nib;
    logic [7:0]                    result;

    // next values; strobes default low so each lasts one clock
    always_comb begin
        diff       = sub_borrow(file_rdata_i, w_r, !c_r);
        nib        = sub_borrow({4'h0, file_rdata_i[3:0]}, {4'h0, w_r[3:0]}, !c_r);
        result     = swap_r ? {file_rdata_i[3:0], file_rdata_i[7:4]} : diff[7:0];
        state_nxt  = state_r;
        cyc_nxt    = cyc_r;
        busy_nxt   = busy_r;
        swap_nxt   = swap_r;
        dest_nxt   = dest_r;
        mode_nxt   = mode_r;
        w_nxt      = w_r;
        c_nxt      = c_r;
        opnd_nxt   = opnd_r;
        faddr_nxt  = faddr_r;
        frd_nxt    = 1'b0;
        fwr_nxt    = 1'b0;
        fwdata_nxt = fwdata_r;
        wwr_nxt    = 1'b0;
        wwdata_nxt = wwdata_r;
        swr_nxt    = 1'b0;
        flags_nxt  = flags_r;
        paddr_nxt  = paddr_r;
        prd_nxt    = 1'b0;
        ptr_nxt    = ptr_r;
        latch_nxt  = latch_r;
        unique case (state_r)
            nsx_pkg::NSX_IDLE: begin
                if (accept) begin
                    cyc_nxt  = nsx_pkg::CYC_FILE_RD;
                    busy_nxt = 1'b1;
                    swap_nxt = is_swap;
                    dest_nxt = opcode_i[nsx_pkg::OPF_DEST];
                    mode_nxt = opcode_i[1:0];
                    w_nxt    = w_i;
                    c_nxt    = carry_i;
                    if (is_tbl) begin
                        state_nxt = nsx_pkg::NSX_TABLE;
                        if (opcode_i[1:0] == nsx_pkg::TBL_PREINC) begin
                            ptr_nxt = ptr_r + PTR_ONE;              // bump before the read
                        end
                    end else begin
                        state_nxt = nsx_pkg::NSX_FILE;
                        faddr_nxt = eff_addr;
                        frd_nxt   = 1'b1;
                    end
                end else if (ptr_load_i) begin
                    ptr_nxt = ptr_data_i;                           // loads only between instructions
                end
            end
            nsx_pkg::NSX_FILE: begin
                cyc_nxt = cyc_r + nsx_pkg::CYC_STEP;
                if (cyc_r == nsx_pkg::CYC_FILE_PROC) begin
                    opnd_nxt = file_rdata_i;
                    if (dest_r) begin
                        fwr_nxt    = 1'b1;                          // back to the source
                        fwdata_nxt = result;
                    end else begin
                        wwr_nxt    = 1'b1;                          // to the accumulator
                        wwdata_nxt = result;
                    end
                    if (!swap_r) begin                              // exchange leaves flags alone
                        swr_nxt                   = 1'b1;
                        flags_nxt[nsx_pkg::FLG_C]  = !diff[8];
                        flags_nxt[nsx_pkg::FLG_DC] = !nib[8];
                        flags_nxt[nsx_pkg::FLG_Z]  = (diff[7:0] == 8'h00);
                        flags_nxt[nsx_pkg::FLG_OV] = (file_rdata_i[7] != w_r[7]) && (diff[7] != file_rdata_i[7]);
                        flags_nxt[nsx_pkg::FLG_N]  = diff[7];
                    end
                end
                if (cyc_r == nsx_pkg::CYC_FILE_LAST) begin          // one instruction cycle
                    state_nxt = nsx_pkg::NSX_IDLE;
                    cyc_nxt   = nsx_pkg::CYC_ZERO;
                    busy_nxt  = 1'b0;
                end
            end
            nsx_pkg::NSX_TABLE: begin
                cyc_nxt = cyc_r + nsx_pkg::CYC_STEP;
                if (cyc_r == nsx_pkg::CYC_PMEM_REQ) begin
                    prd_nxt   = 1'b1;
                    paddr_nxt = ptr_r[PTR_W-1:1];                   // word address
                end
                if (cyc_r == nsx_pkg::CYC_PMEM_CAP) begin
                    latch_nxt = ptr_r[0] ? pmem_rdata_i[15:8] : pmem_rdata_i[7:0];
                    unique case (mode_r)
                        nsx_pkg::TBL_POSTINC: ptr_nxt = ptr_r + PTR_ONE;
                        nsx_pkg::TBL_POSTDEC: ptr_nxt = ptr_r - PTR_ONE;
                        nsx_pkg::TBL_NOCHG:   ptr_nxt = ptr_r;
                        nsx_pkg::TBL_PREINC:  ptr_nxt = ptr_r;      // already bumped
                    endcase
                end
                if (cyc_r == nsx_pkg::CYC_TBL_LAST) begin
                    state_nxt = nsx_pkg::NSX_IDLE;
                    cyc_nxt   = nsx_pkg::CYC_ZERO;
                    busy_nxt  = 1'b0;
                end
            end
            default: begin
                state_nxt = nsx_pkg::NSX_IDLE;                      // recover from an illegal code
                cyc_nxt   = nsx_pkg::CYC_ZERO;
                busy_nxt  = 1'b0;
            end
        endcase
    end

    // registers only
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            state_r  <= nsx_pkg::NSX_IDLE;
            cyc_r    <= nsx_pkg::CYC_ZERO;
            busy_r   <= 1'b0;
            swap_r   <= 1'b0;
            dest_r   <= 1'b0;
            mode_r   <= nsx_pkg::TBL_NOCHG;
            w_r      <= 8'h00;
            c_r      <= 1'b0;
            opnd_r   <= 8'h00;
            faddr_r  <= '0;
            frd_r    <= 1'b0;
            fwr_r    <= 1'b0;
            fwdata_r <= 8'h00;
            wwr_r    <= 1'b0;
            wwdata_r <= 8'h00;
            swr_r    <= 1'b0;
            flags_r  <= '0;
            paddr_r  <= '0;
            prd_r    <= 1'b0;
            ptr_r    <= '0;
            latch_r  <= 8'h00;
        end else begin
            state_r  <= state_nxt;
            cyc_r    <= cyc_nxt;
            busy_r   <= busy_nxt;
            swap_r   <= swap_nxt;
            dest_r   <= dest_nxt;
            mode_r   <= mode_nxt;
            w_r      <= w_nxt;
            c_r      <= c_nxt;
            opnd_r   <= opnd_nxt;
            faddr_r  <= faddr_nxt;
            frd_r    <= frd_nxt;
            fwr_r    <= fwr_nxt;
            fwdata_r <= fwdata_nxt;
            wwr_r    <= wwr_nxt;
            wwdata_r <= wwdata_nxt;
            swr_r    <= swr_nxt;
            flags_r  <= flags_nxt;
            paddr_r  <= paddr_nxt;
            prd_r    <= prd_nxt;
            ptr_r    <= ptr_nxt;
            latch_r  <= latch_nxt;
        end
    end

    // outputs straight from the registers
    assign busy_o               = busy_r;
    assign file_addr_o          = faddr_r;
    assign file_rd_o            = frd_r;
    assign file_wr_o            = fwr_r;
    assign file_wdata_o         = fwdata_r;
    assign w_wr_o               = wwr_r;
    assign w_wdata_o            = wwdata_r;
    assign status_wr_o          = swr_r;
    assign flags_o              = flags_r;
    assign pmem_addr_o          = paddr_r;
    assign pmem_rd_o            = prd_r;
    assign program_pointer_o    = ptr_r;
    assign fetched_byte_latch_o = latch_r;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking nsx_cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    a_swap_nibbles: assert property (file_wr_o && swap_r |-> file_wdata_o == {opnd_r[3:0], opnd_r[7:4]})
        else $error("exchanged nibbles wrong");
    a_swap_dest: assert property (
        accept && is_swap |-> ##3 (file_wr_o == $past(opcode_i[nsx_pkg::OPF_DEST], 3)) && (w_wr_o != file_wr_o))
        else $error("exchange result went to wrong destination");
    a_bank_select: assert property (
        accept && !is_tbl && opcode_i[nsx_pkg::OPF_BANK]
        |=> file_addr_o == {$past(bank_select_register_i), $past(f_field)})
        else $error("banked address wrong");
    a_indexed_offset: assert property (
        accept && !is_tbl && !opcode_i[nsx_pkg::OPF_BANK] && ext_set_i && (f_field <= nsx_pkg::ILO_LIMIT)
        |=> file_addr_o == $past(ilo_base_i) + {{BANK_SEL_W{1'b0}}, $past(f_field)})
        else $error("indexed literal offset address wrong");
    a_tbl_nochange: assert property (
        accept && is_tbl && opcode_i[1:0] == nsx_pkg::TBL_NOCHG
        |-> ##8 program_pointer_o == $past(program_pointer_o, 8))
        else $error("pointer moved in no-change mode");
    a_tbl_postinc: assert property (
        accept && is_tbl && opcode_i[1:0] == nsx_pkg::TBL_POSTINC
        |-> ##5 (pmem_addr_o == $past(program_pointer_o[PTR_W-1:1], 5)) ##3
        program_pointer_o == $past(program_pointer_o, 8) + PTR_ONE)
        else $error("post-increment wrong");
    a_tbl_postdec: assert property (
        accept && is_tbl && opcode_i[1:0] == nsx_pkg::TBL_POSTDEC
        |-> ##5 (pmem_addr_o == $past(program_pointer_o[PTR_W-1:1], 5)) ##3
        program_pointer_o == $past(program_pointer_o, 8) - PTR_ONE)
        else $error("post-decrement wrong");
    a_tbl_preinc: assert property (
        accept && is_tbl && opcode_i[1:0] == nsx_pkg::TBL_PREINC
        |=> program_pointer_o == $past(program_pointer_o) + PTR_ONE ##4 pmem_rd_o
        && pmem_addr_o == program_pointer_o[PTR_W-1:1])
        else $error("pre-increment wrong");
    a_byte_select: assert property (
        state_r == nsx_pkg::NSX_TABLE && cyc_r == nsx_pkg::CYC_PMEM_CAP
        |=> fetched_byte_latch_o == ($past(program_pointer_o[0]) ? $past(pmem_rdata_i[15:8])
        : $past(pmem_rdata_i[7:0])))
        else $error("wrong byte of program word latched");
    a_borrow_sub: assert property (
        status_wr_o |-> ((dest_r ? file_wdata_o : w_wdata_o) == 8'(opnd_r - w_r - {7'h00, !c_r}))
        && (flags_o[nsx_pkg::FLG_Z] == ((dest_r ? file_wdata_o : w_wdata_o) == 8'h00))
        && (flags_o[nsx_pkg::FLG_C] == ({1'b0, opnd_r} >= ({1'b0, w_r} + {8'h00, !c_r}))))
        else $error("subtract with borrow result wrong");
    a_swap_cycle: assert property (accept && is_swap |=> !status_wr_o [*3] ##1 !busy_o)
        else $error("exchange touched flags or overran a cycle");

endmodule
`default_nettype wire

// File: verification/nsx_mem_model.sv
// behavioural data register file and program memory facing the executor
`timescale 1ns/100ps
`default_nettype none

module nsx_mem_model (
    // clock
    input  wire logic        clk_sys_i,
    // data register file side
    input  wire logic [13:0] file_addr_i,
    input  wire logic        file_rd_i,
    input  wire logic        file_wr_i,
    input  wire logic [7:0]  file_wdata_i,
    // program memory side
    input  wire logic [19:0] pmem_addr_i,
    input  wire logic        pmem_rd_i,
    // read data
    output logic      [7:0]  file_rdata_o,
    output logic      [15:0] pmem_rdata_o
);
    logic [7:0]  fmem [0:16383];
    logic [15:0] pmem [int];

    // data is valid only in the cycle after a read strobe; otherwise the lines toggle
    // so a design that samples an odd number of cycles late never sees a lucky stale value
    always @(posedge clk_sys_i) begin
        if (file_rd_i) file_rdata_o <= fmem[file_addr_i];
        else file_rdata_o <= ~file_rdata_o;
        if (file_wr_i) fmem[file_addr_i] <= file_wdata_i;
        if (pmem_rd_i) pmem_rdata_o <= pmem[int'(pmem_addr_i)];
        else pmem_rdata_o <= ~pmem_rdata_o;
    end
endmodule

`default_nettype wire

// File: verification/nibble_swap_and_table_read_exec_bench.sv
// self-checking bench for the nibble-exchange / table-read executor
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] %0t value mismatch: got %0h exp %0h", $time, got, exp); end end

module nibble_swap_and_table_read_exec_bench;
    logic        clk_sys_i = 1'b0;
    logic        rstn_i    = 1'b0;
    logic        issue     = 1'b0;
    logic [15:0] opcode    = 16'h0000;
    logic [7:0]  w_in      = 8'h00;
    logic        carry     = 1'b0;
    logic [5:0]  bank_sel  = 6'h00;
    logic        ext_set   = 1'b0;
    logic [13:0] ilo_base  = 14'h0100;
    logic        ptr_load  = 1'b0;
    logic [20:0] ptr_data  = 21'h0;
    logic [7:0]  file_rdata, file_wdata, w_wdata, latch;
    logic [15:0] pmem_rdata;
    logic [13:0] file_addr;
    logic [19:0] pmem_addr;
    logic [20:0] pptr;
    logic [4:0]  flags;
    logic        busy, file_rd, file_wr, w_wr, status_wr, pmem_rd;
    int          mismatches   = 0;
    int          total_checks = 0;
    int          n_fwr, n_wwr, n_swr, n_prd, cyc;

    nsx_exec u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .issue_i(issue), .opcode_i(opcode), .w_i(w_in),
        .carry_i(carry), .bank_select_register_i(bank_sel), .ext_set_i(ext_set), .ilo_base_i(ilo_base),
        .ptr_load_i(ptr_load),
        .ptr_data_i(ptr_data), .file_rdata_i(file_rdata), .pmem_rdata_i(pmem_rdata), .busy_o(busy),
        .file_addr_o(file_addr), .file_rd_o(file_rd), .file_wr_o(file_wr), .file_wdata_o(file_wdata),
        .w_wr_o(w_wr), .w_wdata_o(w_wdata), .status_wr_o(status_wr), .flags_o(flags),
        .pmem_addr_o(pmem_addr), .pmem_rd_o(pmem_rd), .program_pointer_o(pptr), .fetched_byte_latch_o(latch));

    nsx_mem_model u_mem (.clk_sys_i(clk_sys_i), .file_addr_i(file_addr), .file_rd_i(file_rd),
        .file_wr_i(file_wr), .file_wdata_i(file_wdata), .pmem_addr_i(pmem_addr), .pmem_rd_i(pmem_rd),
        .file_rdata_o(file_rdata), .pmem_rdata_o(pmem_rdata));

    // 20 MHz system clock
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    // strobe counters, cleared by each operation
    always @(posedge clk_sys_i) begin
        n_fwr += int'(file_wr === 1'b1);
        n_wwr += int'(w_wr === 1'b1);
        n_swr += int'(status_wr === 1'b1);
        n_prd += int'(pmem_rd === 1'b1);
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // offer one instruction at a falling edge, then count busy cycles; bounded so a hang cannot stall
    task automatic run_op(input logic [15:0] op, input logic [7:0] w, input logic c);
        n_fwr = 0; n_wwr = 0; n_swr = 0; n_prd = 0; cyc = 0;
        opcode = op; w_in = w; carry = c; issue = 1'b1;
        @(negedge clk_sys_i);
        issue = 1'b0;
        while (busy === 1'b1 && cyc < 20) begin
            cyc++;
            @(negedge clk_sys_i);
        end
    endtask

    task automatic test_swap_addr();
        logic        ax [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        logic        aa [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        logic [7:0]  af [6] = '{8'h80, 8'ha7, 8'h5f, 8'h60, 8'h20, 8'h10};
        logic [13:0] ae [6] = '{14'h3f80, 14'h05a7, 14'h015f, 14'h3f60, 14'h0020, 14'h0510};
        logic [7:0]  v;
        for (int i = 0; i < 6; i++) begin
            v = 8'h53 + 8'(i * 17);
            ext_set = ax[i]; bank_sel = 6'h05;
            u_mem.fmem[ae[i]] = v;
            run_op({nsx_pkg::OPC_SWAP, 1'b1, aa[i], af[i]}, 8'hee, 1'b0);
            `CHK(file_addr, ae[i])
            `CHK(u_mem.fmem[ae[i]], {v[3:0], v[7:4]})
            `CHK(cyc, 3)
            `CHK({n_fwr, n_wwr, n_swr}, {32'd1, 32'd0, 32'd0})
        end
        $display("test swap_addr done");
    endtask

    task automatic test_swap_to_w();
        ext_set = 1'b0;
        u_mem.fmem[14'h0031] = 8'h53;
        run_op({nsx_pkg::OPC_SWAP, 1'b0, 1'b0, 8'h31}, 8'h00, 1'b1);
        `CHK(w_wdata, 8'h35)
        `CHK(u_mem.fmem[14'h0031], 8'h53)
        `CHK({n_fwr, n_wwr, n_swr}, {32'd0, 32'd1, 32'd0})
        $display("test swap_to_w done");
    endtask

    task automatic test_subb();
        u_mem.fmem[14'h0040] = 8'h1b;
        run_op({nsx_pkg::OPC_SUBB, 1'b0, 1'b0, 8'h40}, 8'h1a, 1'b0);
        `CHK(w_wdata, 8'h00)
        `CHK(flags, 5'b00111)
        `CHK(n_swr, 1)
        u_mem.fmem[14'h0041] = 8'h03;
        run_op({nsx_pkg::OPC_SUBB, 1'b1, 1'b0, 8'h41}, 8'h0e, 1'b1);
        `CHK(u_mem.fmem[14'h0041], 8'hf5)
        `CHK(flags, 5'b10000)
        $display("test subb done");
    endtask

    task automatic test_table();
        logic [1:0]  md [5] = '{nsx_pkg::TBL_NOCHG, nsx_pkg::TBL_POSTINC, nsx_pkg::TBL_POSTDEC,
                                nsx_pkg::TBL_PREINC, nsx_pkg::TBL_POSTDEC};
        logic [20:0] ps [5] = '{21'ha357, 21'ha356, 21'h1_a357, 21'h1_a357, 21'h0};
        logic [20:0] pe [5] = '{21'ha357, 21'ha357, 21'h1_a356, 21'h1_a358, 21'h1f_ffff};
        logic [7:0]  le [5] = '{8'h9c, 8'h34, 8'h12, 8'h34, 8'hc3};
        u_mem.pmem[32'h51ab] = 16'h9c34;
        u_mem.pmem[32'hd1ab] = 16'h1277;
        u_mem.pmem[32'hd1ac] = 16'h5634;
        u_mem.pmem[0] = 16'ha5c3;
        for (int i = 0; i < 5; i++) begin
            ptr_data = ps[i]; ptr_load = 1'b1;
            @(negedge clk_sys_i);
            ptr_load = 1'b0;
            `CHK(pptr, ps[i])
            run_op({nsx_pkg::OPC_PMEM_RD, md[i]}, 8'h00, 1'b0);
            `CHK(latch, le[i])
            `CHK(pptr, pe[i])
            `CHK({cyc, n_prd}, {32'd7, 32'd1})
        end
        $display("test table done");
    endtask

    task automatic test_refuse();
        run_op(16'hffff, 8'h00, 1'b0);
        `CHK({cyc, n_fwr, n_wwr, n_prd}, {32'd0, 32'd0, 32'd0, 32'd0})
        // an offer and a pointer load held up through a running read must both be dropped
        @(negedge clk_sys_i);
        u_mem.pmem[32'hf_ffff] = 16'h7e81;
        n_fwr = 0; n_wwr = 0; n_prd = 0;
        opcode = {nsx_pkg::OPC_PMEM_RD, nsx_pkg::TBL_NOCHG}; issue = 1'b1;
        @(negedge clk_sys_i);
        opcode = {nsx_pkg::OPC_SWAP, 1'b1, 1'b0, 8'h31}; ptr_data = 21'h0_1234; ptr_load = 1'b1;
        repeat (7) @(negedge clk_sys_i);
        issue = 1'b0; ptr_load = 1'b0;
        `CHK({busy, latch, pptr}, {1'b0, 8'h7e, 21'h1f_ffff})
        `CHK({n_fwr, n_wwr, n_prd}, {32'd0, 32'd0, 32'd1})
        $display("test refuse done");
    endtask

    // watchdog: the whole sequence needs well under 400 cycles
    initial begin
        repeat (4000) @(posedge clk_sys_i);
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (4) @(negedge clk_sys_i);
        `CHK({busy, pptr, latch}, 30'h0)
        rstn_i = 1'b1;
        $display("test reset done");
        test_swap_addr();
        test_swap_to_w();
        test_subb();
        test_table();
        test_refuse();
        end_sim();
    end
endmodule

`default_nettype wire
